/* File: rtl/fsm_bus_ctrl.sv */
// Host controller driving the stacked flash/SRAM asynchronous bus
//
// Summary of operation
// - Flash read: select, gate low, SRAM off
// - Flash write: select, strobe low, gate high
// - Guard high during flash writes; supply pin follows req_high_supply only
// - Never select flash and SRAM together
// - Byte enables separate for 8-bit access
// - Select edge needed after reset release
`timescale 1ns/10ps
`default_nettype none
module fsm_bus_ctrl
  import fsm_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic [1:0] req_byte_en,
  input wire logic req_flash_reset,
  input wire logic req_unlock_ok,
  input wire logic req_high_supply,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  output logic [AW-1:0] bus_addr,
  output logic [DW-1:0] shared_data_bus_out,
  output logic shared_data_bus_oe,
  input wire logic [DW-1:0] shared_data_bus_in,
  output logic flash_select_n,
  output logic flash_output_gate_n,
  output logic flash_write_strobe_n,
  output logic flash_reset_n,
  output logic flash_lockdown_guard_n,
  output logic program_supply_pin,
  output logic sram_select_low_n,
  output logic sram_select_high,
  output logic sram_output_gate_n,
  output logic sram_write_strobe_n,
  output logic sram_upper_byte_en_n,
  output logic sram_lower_byte_en_n
);
  // Widths and counts outside what the sequencer can serve
  if (AW < SRAM_ADDR_W || DW != DATA_W || ACCESS_CYC + 2 >= (1 << CNT_W)) begin : g_bad_cfg
    $error("fsm_bus_ctrl: unsupported parameters");
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [DW-1:0] data_sync;
  fsm_sync #(.WIDTH(DW)) u_data_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(shared_data_bus_in),
    .sync_out(data_sync)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  fsm_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] op_reg;

  // Request decoding
  wire is_read = (op_reg == OP_FLASH_READ) || (op_reg == OP_SRAM_READ);
  wire take_req = (state_reg == FSM_IDLE) && req_valid && !req_flash_reset;
  wire cnt_zero = (cnt_reg == '0);
  wire [CNT_W-1:0] strobe_len = is_read ? CNT_W'(ACCESS_CYC + 2) : CNT_W'(WRITE_CYC);

  // Next-state selection; sampled data lags two flops, hence +2 on reads
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
    case (state_reg)
      FSM_IDLE: begin
        if (req_flash_reset) begin
          state_next = FSM_RESET;
          cnt_next = CNT_W'(RESET_CYC);
        end else if (req_valid) begin
          state_next = FSM_SETUP;
          cnt_next = CNT_W'(TURN_CYC);
        end
      end
      FSM_RESET: begin
        if (cnt_zero && !req_flash_reset) begin
          state_next = FSM_IDLE;
        end
      end
      FSM_SETUP: begin
        if (cnt_zero) begin
          state_next = FSM_STROBE;
          cnt_next = strobe_len;
        end
      end
      FSM_STROBE: begin
        if (cnt_zero) begin
          state_next = FSM_RELEASE;
          cnt_next = CNT_W'(TURN_CYC);
        end
      end
      FSM_RELEASE: begin
        if (cnt_zero) begin
          state_next = FSM_IDLE;
        end
      end
      default: state_next = FSM_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin value decoding
  // ----------------------------------------------------------------
  wire active = (state_reg == FSM_SETUP) || (state_reg == FSM_STROBE)
    || (state_reg == FSM_RELEASE);
  wire strobing = (state_next == FSM_STROBE);
  wire active_next = take_req || (active && state_next != FSM_IDLE);
  wire [1:0] op_next = take_req ? req_op : op_reg;
  wire flash_next = (op_next == OP_FLASH_READ) || (op_next == OP_FLASH_WRITE);
  wire read_next = (op_next == OP_FLASH_READ) || (op_next == OP_SRAM_READ);
  // Only one memory is ever selected; the other is held off
  wire fsel_next = active_next && flash_next && state_next != FSM_RESET;
  wire ssel_next = active_next && !flash_next;
  // Write strobe rises two cycles before select drops, so it latches first
  wire fwr_next = fsel_next && !read_next && strobing;
  wire frd_next = fsel_next && read_next && strobing;
  wire swr_next = ssel_next && !read_next && strobing;
  wire srd_next = ssel_next && read_next && strobing;
  wire drive_next = active_next && !read_next;
  // Full word unless the user asks for one byte
  wire [1:0] be_next = take_req ? req_byte_en : (active ? ~{sram_upper_byte_en_n,
    sram_lower_byte_en_n} : BYTE_BOTH);
  wire capture = active && is_read && state_reg == FSM_STROBE && cnt_zero;

  // State and counter registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= FSM_IDLE;
      cnt_reg <= '0;
      op_reg <= OP_FLASH_READ;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
    end
  end

  // Control pins straight from flops; idle leaves both memories in standby
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_select_n <= 1'b1;
      flash_output_gate_n <= 1'b1;
      flash_write_strobe_n <= 1'b1;
      flash_reset_n <= 1'b0;
      sram_select_low_n <= 1'b1;
      sram_select_high <= 1'b0;
      sram_output_gate_n <= 1'b1;
      sram_write_strobe_n <= 1'b1;
      sram_upper_byte_en_n <= 1'b1;
      sram_lower_byte_en_n <= 1'b1;
    end else begin
      flash_select_n <= !fsel_next;
      flash_output_gate_n <= !frd_next;
      flash_write_strobe_n <= !fwr_next;
      flash_reset_n <= (state_next != FSM_RESET);
      sram_select_low_n <= !ssel_next;
      sram_select_high <= ssel_next;
      sram_output_gate_n <= !srd_next;
      sram_write_strobe_n <= !swr_next;
      sram_upper_byte_en_n <= !(ssel_next && be_next[1]);
      sram_lower_byte_en_n <= !(ssel_next && be_next[0]);
    end
  end

  // Address, data and supply pins; guard high lets software unlock
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_addr <= '0;
      shared_data_bus_out <= '0;
      shared_data_bus_oe <= 1'b0;
      flash_lockdown_guard_n <= 1'b0;
      program_supply_pin <= 1'b0;
    end else begin
      if (take_req) begin
        bus_addr <= req_addr;
        shared_data_bus_out <= req_wdata;
      end
      shared_data_bus_oe <= drive_next;
      // Held high through flash writes so commands are not locked out
      flash_lockdown_guard_n <= req_unlock_ok || (fsel_next && !read_next);
      program_supply_pin <= req_high_supply;
    end
  end

  // Answer to the user
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      req_ready <= (state_next == FSM_IDLE) && !take_req;
      rsp_valid <= (state_reg == FSM_RELEASE) && cnt_zero;
      if (capture) begin
        rsp_rdata <= data_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  exclusive_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(!flash_select_n && !sram_select_low_n && sram_select_high))
    else $error("flash and SRAM selected together");
  flash_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !flash_output_gate_n |-> !flash_select_n && flash_write_strobe_n && flash_reset_n)
    else $error("flash read pins inconsistent");
  flash_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !flash_write_strobe_n |-> !flash_select_n && flash_output_gate_n && flash_lockdown_guard_n)
    else $error("flash write pins inconsistent");
  strobe_first_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(flash_write_strobe_n) |-> !flash_select_n)
    else $error("select rose with write strobe");
  sram_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sram_write_strobe_n |-> sram_output_gate_n && !sram_select_low_n && shared_data_bus_oe)
    else $error("SRAM write pins inconsistent");
  sram_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sram_output_gate_n |-> !shared_data_bus_oe && sram_write_strobe_n && sram_select_high)
    else $error("SRAM read pins inconsistent");
  reset_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(flash_reset_n) |-> !flash_reset_n [*4])
    else $error("flash reset pulse too short");
  reset_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !flash_reset_n |-> flash_select_n && flash_write_strobe_n)
    else $error("flash accessed during reset");
endmodule : fsm_bus_ctrl
`default_nettype wire

/* File: rtl/fsm_pkg.sv */
// Package of constants and types for the flash/SRAM bus controller
package fsm_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int SRAM_ADDR_W = 18;
  localparam int CLK_PERIOD_NS = 25;
  // ----------------------------------------------------------------
  // Timing figures in ns and derived cycles
  // ----------------------------------------------------------------
  localparam int ACCESS_NS = 70;
  localparam int WRITE_PULSE_NS = 50;
  localparam int TURN_NS = 25;
  localparam int RESET_PULSE_NS = 100;
  localparam int AUTO_STBY_NS = 150;
  // Least times round up, never below one cycle
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUTO_STBY_CYC = (AUTO_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // ----------------------------------------------------------------
  // Request codes and states
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_FLASH_READ = 2'h0;
  localparam logic [1:0] OP_FLASH_WRITE = 2'h1;
  localparam logic [1:0] OP_SRAM_READ = 2'h2;
  localparam logic [1:0] OP_SRAM_WRITE = 2'h3;
  localparam logic [1:0] BYTE_BOTH = 2'h3;
  typedef enum logic [2:0] {
    FSM_IDLE,
    FSM_RESET,
    FSM_SETUP,
    FSM_STROBE,
    FSM_RELEASE
  } fsm_state_e;
endpackage : fsm_pkg

/* File: rtl/fsm_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module fsm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  // A zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("fsm_sync: width must be at least one");
  end
  // First flop feeds only the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : fsm_sync
`default_nettype wire

/* File: bench/fsm_dev_model.sv */
// Behavioural flash and SRAM pair answering on the shared bus
`timescale 1ns/10ps
`default_nettype none
module fsm_dev_model
  import fsm_pkg::*;
(
  input wire logic flash_select_n,
  input wire logic flash_output_gate_n,
  input wire logic flash_write_strobe_n,
  input wire logic flash_reset_n,
  input wire logic sram_select_low_n,
  input wire logic sram_select_high,
  input wire logic sram_output_gate_n,
  input wire logic sram_write_strobe_n,
  input wire logic sram_upper_byte_en_n,
  input wire logic sram_lower_byte_en_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] host_data,
  output logic [DATA_W-1:0] dev_data,
  output logic clash
);
  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] flash_mem [256];
  logic [DATA_W-1:0] sram_mem [256];
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic [DATA_W-1:0] val;
  wire logic [7:0] a = bus_addr[7:0];
  wire logic sram_on = !sram_select_low_n && sram_select_high;
  // Flash answers from the array only while select and gate are low and reset is released
  wire logic f_rd = !flash_select_n && !flash_output_gate_n
    && flash_reset_n;
  wire logic s_rd = sram_on && !sram_output_gate_n && sram_write_strobe_n;
  assign clash = !flash_select_n && sram_on;
  // Released lines show the inverse of the last word, never a held value
  always @* begin
    val = ~last_q;
    if (f_rd) val = flash_mem[a];
    if (s_rd && !sram_upper_byte_en_n) val[15:8] = sram_mem[a][15:8];
    if (s_rd && !sram_lower_byte_en_n) val[7:0] = sram_mem[a][7:0];
  end
  assign dev_data = val;
  // Only driven lanes are remembered; a floating lane feeding back would never settle
  always @(val) begin
    if (f_rd) last_q = val;
    if (s_rd && !sram_upper_byte_en_n) last_q[15:8] = val[15:8];
    if (s_rd && !sram_lower_byte_en_n) last_q[7:0] = val[7:0];
  end
  // Flash latches on whichever of strobe or select rises first
  // Program ends at the latch, so standby never cuts it short; reset drops it
  always @(posedge flash_write_strobe_n or posedge flash_select_n)
    if ((!flash_write_strobe_n || !flash_select_n) && flash_output_gate_n && flash_reset_n)
      flash_mem[a] <= host_data;
  // SRAM word or byte write on the closing strobe edge
  always @(posedge sram_write_strobe_n)
    if (sram_on && sram_output_gate_n) begin
      if (!sram_upper_byte_en_n) sram_mem[a][15:8] <= host_data[15:8];
      if (!sram_lower_byte_en_n) sram_mem[a][7:0] <= host_data[7:0];
    end
endmodule : fsm_dev_model
`default_nettype wire

/* File: bench/fsm_bus_ctrl_tb.sv */
// Self-checking bench for the flash/SRAM bus controller
`timescale 1ns/10ps
`default_nettype none
module fsm_bus_ctrl_tb
  import fsm_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0, req_flash_reset = 1'b0, req_unlock_ok = 1'b0, req_high_supply = 1'b0;
  logic [1:0] req_op = 2'h0, req_byte_en = 2'h3;
  logic [ADDR_W-1:0] req_addr = 21'h000000;
  logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, shared_data_bus_out, dev_data;
  logic [ADDR_W-1:0] bus_addr;
  logic req_ready, rsp_valid, shared_data_bus_oe, flash_select_n, flash_output_gate_n, clash;
  logic flash_write_strobe_n, flash_reset_n, flash_lockdown_guard_n, program_supply_pin;
  logic sram_select_low_n, sram_select_high, sram_output_gate_n, sram_write_strobe_n;
  logic sram_upper_byte_en_n, sram_lower_byte_en_n;
  wire logic [DATA_W-1:0] bus = shared_data_bus_oe ? shared_data_bus_out : dev_data;
  int errors = 0, total_checks = 0;
  // ----------------------------------------------------------------
  // Design, device model and clock
  // ----------------------------------------------------------------
  fsm_bus_ctrl dut (.core_clk, .sys_rst, .req_valid, .req_op, .req_addr, .req_wdata,
    .req_byte_en, .req_flash_reset, .req_unlock_ok, .req_high_supply, .req_ready, .rsp_valid,
    .rsp_rdata, .bus_addr, .shared_data_bus_out, .shared_data_bus_oe, .shared_data_bus_in(bus),
    .flash_select_n, .flash_output_gate_n, .flash_write_strobe_n, .flash_reset_n,
    .flash_lockdown_guard_n, .program_supply_pin, .sram_select_low_n, .sram_select_high,
    .sram_output_gate_n, .sram_write_strobe_n, .sram_upper_byte_en_n, .sram_lower_byte_en_n);
  fsm_dev_model dev (.flash_select_n, .flash_output_gate_n, .flash_write_strobe_n,
    .flash_reset_n, .sram_select_low_n, .sram_select_high, .sram_output_gate_n,
    .sram_write_strobe_n, .sram_upper_byte_en_n, .sram_lower_byte_en_n, .bus_addr,
    .host_data(bus), .dev_data, .clash);
  always #12.5 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Inputs move a fixed 2 ns after the rising edge
  task automatic tick();
    @(posedge core_clk);
    #2;
  endtask : tick
  // One transfer; waits are bounded so a hang ends the run
  task automatic xfer(input logic [1:0] op, input logic [ADDR_W-1:0] ad, input logic [15:0] wd,
                      input logic [1:0] be);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    req_op = op;
    req_addr = ad;
    req_wdata = wd;
    req_byte_en = be;
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    if (n >= 50) begin
      errors++;
      complete_run();
    end
  endtask : xfer
  // Pin levels checked at every write strobe fall, and bus clash every cycle
  always @(negedge flash_write_strobe_n) check("flash write pins", 16'h0003,
    {14'h0000, flash_lockdown_guard_n, flash_output_gate_n});
  always @(negedge sram_write_strobe_n) check("sram write pins", 16'h0003,
    {14'h0000, flash_select_n, sram_output_gate_n});
  always @(posedge core_clk) if (clash === 1'b1) check("bus clash", 16'h0000, 16'h0001);
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check("reset pins", 16'h0018, {10'h000, flash_reset_n, flash_select_n,
      sram_select_low_n, sram_select_high, shared_data_bus_oe, req_ready});
    sys_rst = 1'b0;
    tick();
    tick();
    check("after reset", 16'h0003, {14'h0000, flash_reset_n, req_ready});
    $display("test reset done");
  endtask : test_reset
  task automatic test_flash();
    xfer(OP_FLASH_WRITE, 21'h1F8005, 16'hA55A, BYTE_BOTH);
    check("flash address low", 16'h8005, bus_addr[15:0]);
    check("flash address top", 16'h001F, {11'h000, bus_addr[20:16]});
    xfer(OP_FLASH_READ, 21'h1F8005, 16'h0000, BYTE_BOTH);
    check("flash read", 16'hA55A, rsp_rdata);
    $display("test flash done");
  endtask : test_flash
  task automatic test_sram();
    xfer(OP_SRAM_WRITE, 21'h000010, 16'h1357, BYTE_BOTH);
    xfer(OP_SRAM_WRITE, 21'h000010, 16'hBEEF, 2'h2);
    xfer(OP_SRAM_READ, 21'h000010, 16'h0000, BYTE_BOTH);
    check("sram word", 16'hBE57, rsp_rdata);
    xfer(OP_SRAM_READ, 21'h000010, 16'h0000, 2'h1);
    check("sram low byte", 16'h0057, {8'h00, rsp_rdata[7:0]});
    $display("test sram done");
  endtask : test_sram
  task automatic test_freset();
    req_flash_reset = 1'b1;
    repeat (6) tick();
    check("flash reset pins", 16'h0002, {14'h0000, flash_select_n, flash_reset_n});
    req_flash_reset = 1'b0;
    xfer(OP_FLASH_READ, 21'h1F8005, 16'h0000, BYTE_BOTH);
    check("read after reset", 16'hA55A, rsp_rdata);
    $display("test flash reset done");
  endtask : test_freset
  task automatic test_pins();
    req_unlock_ok = 1'b1;
    req_high_supply = 1'b1;
    tick();
    tick();
    check("guard supply on", 16'h0003, {14'h0000,
      flash_lockdown_guard_n, program_supply_pin});
    req_unlock_ok = 1'b0;
    req_high_supply = 1'b0;
    tick();
    tick();
    check("guard supply off", 16'h0000, {14'h0000,
      flash_lockdown_guard_n, program_supply_pin});
    $display("test pins done");
  endtask : test_pins
  initial begin
    repeat (4) @(posedge core_clk);
    #2;
    test_reset();
    test_flash();
    test_sram();
    test_freset();
    test_pins();
    complete_run();
  end
endmodule : fsm_bus_ctrl_tb
`default_nettype wire
